// *** shared/taskfile_pkg.sv ***
// constants for the task file status and control register bank
package taskfile_pkg;
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFS_UNIT_HEAD = 4'h6;
   localparam logic [3:0] OFS_CONDITION = 4'h7;
   localparam logic [3:0] OFS_MIRROR = 4'hE;
   localparam logic [3:0] OFS_CONTROL = 4'hE;
   localparam logic [3:0] OFS_READBACK = 4'hF;
   // unit/head select fields
   localparam int UH_LBA_BIT = 6;
   localparam int UH_UNIT_BIT = 4;
   localparam logic [7:0] UH_FIXED_ONES = 8'hA0;
   localparam logic [7:0] UH_RESET = 8'hA0;
   // status fields
   localparam int ST_BUSY = 7;
   localparam int ST_READY = 6;
   localparam int ST_WFAULT = 5;
   localparam int ST_SEEK = 4;
   localparam int ST_XFER = 3;
   localparam int ST_FIXED = 2;
   localparam int ST_INDEX = 1;
   localparam int ST_ERR = 0;
   // control fields
   localparam int CT_SRST = 2;
   localparam int CT_IRQ_OFF = 1;
   localparam logic [7:0] DIAG_CODE_RESET = 8'h01;
   localparam logic [7:0] READBACK_TOP = 8'h80;
endpackage

// *** rtl/taskfile_status_ctrl.sv ***
// task file status, device control, unit/head and drive address registers
`timescale 1ns/10ps
// Overview of operation
// - unit/head bit 0 is head bit 0 in CHS, address bit 24 in LOGICAL_BLOCK_MODE
// - logical block mode bit zero picks CHS, one picks LOGICAL_BLOCK_MODE
// - unit select chooses master or slave; card answers when matching its unit
// - status readable at offset 7h and mirror at offset Eh
// - reading primary status clears the pending interrupt
// - reading the mirror leaves the pending interrupt alone
// - busy bit set while card owns command path; other bits invalid
// - ready bit clear from power-up until card accepts commands
// - bit 5 reports a write fault
// - bit 4 set whenever the card is ready
// - transfer request bit set on need, cleared by next command
// - bit 2 reports a corrected error, multi-sector read continues
// - bit 1 always reads zero
// - error bit set on failed command, cleared by next command
// - failing sector address left in the address registers
// - control register writable at offset Eh at any time, even busy
// - soft reset held while control bit 2 is one, clears status
// - control bit 1 low enables interrupt, high masks it; zero at reset
// - drive address register at Fh is read-only, bit 7 undefined
// - drive address bit 6 low while a write is in progress
// - drive address bits 5..2 are inverted unit/head bits 3..0
// - drive address bit 1 or 0 low when that unit is active and selected
module taskfile_status_ctrl
   import taskfile_pkg::*;
#(
   parameter int ADDR_WIDTH = ADDR_W
)
(
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic [ADDR_WIDTH-1:0] ADDR_I,
   input wire logic RD_I,
   input wire logic WR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic UNIT_NUMBER_I,
   input wire logic CORE_BUSY_I,
   input wire logic CORE_READY_I,
   input wire logic WRITE_FAULT_I,
   input wire logic XFER_SET_I,
   input wire logic XFER_DONE_I,
   input wire logic FIXED_DATA_I,
   input wire logic CMD_FAIL_I,
   input wire logic NEW_CMD_I,
   input wire logic WRITE_ACTIVE_I,
   input wire logic IRQ_EVENT_I,
   output logic [7:0] RDATA_O,
   output logic CARD_IRQ_N_O,
   output logic IRQ_CFG_BIT_O,
   output logic SOFT_RESET_O,
   output logic [7:0] DIAG_CODE_O,
   output logic DIAG_LOAD_O,
   output logic LOGICAL_BLOCK_MODE_O,
   output logic [3:0] ADDR_TOP_NIBBLE_O,
   output logic UNIT_MATCH_O
);

   logic [7:0] unit_and_head_select;
   logic soft_reset_bit;
   logic irq_off;
   logic irq_pending;
   logic write_fault_flag;
   logic transfer_request_flag;
   logic fixed_data_flag;
   logic error_flag;
   logic soft_reset_q;
   logic [7:0] card_condition;
   logic [7:0] unit_selection_readback;
   logic unit_select;
   logic unit_match;
   logic write_gate_n;
   logic unit1_selected_n;
   logic unit0_selected_n;
   logic rd_status;

   function automatic logic hit(input logic [ADDR_WIDTH-1:0] a,
                                input logic [3:0] ofs);
      hit = (a == ADDR_WIDTH'(ofs));
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // combinational views

   assign unit_select = unit_and_head_select[UH_UNIT_BIT];
   assign unit_match = (unit_select == UNIT_NUMBER_I);
   assign rd_status = RD_I && hit(ADDR_I, OFS_CONDITION);
   assign write_gate_n = ~WRITE_ACTIVE_I;
   assign unit1_selected_n = ~(unit_select && UNIT_NUMBER_I);
   assign unit0_selected_n = ~(!unit_select && !UNIT_NUMBER_I);

   always_comb
   begin
      card_condition = '0;
      card_condition[ST_BUSY] = CORE_BUSY_I | soft_reset_bit;
      card_condition[ST_READY] = CORE_READY_I & ~soft_reset_bit;
      card_condition[ST_WFAULT] = write_fault_flag;
      card_condition[ST_SEEK] = CORE_READY_I & ~soft_reset_bit;
      card_condition[ST_XFER] = transfer_request_flag;
      card_condition[ST_FIXED] = fixed_data_flag;
      card_condition[ST_INDEX] = 1'b0;
      card_condition[ST_ERR] = error_flag;
   end

   // bit 7 is undefined on the pins; driven as a fixed value here
   assign unit_selection_readback = READBACK_TOP
      | {1'b0, write_gate_n, ~unit_and_head_select[3:0],
         unit1_selected_n, unit0_selected_n};

   ////////////////////////////////////////////////////////////////////////
   // unit/head select register

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
         unit_and_head_select <= UH_RESET;
      else if (WR_I && hit(ADDR_I, OFS_UNIT_HEAD))
         unit_and_head_select <= WDATA_I | UH_FIXED_ONES;
   end

   // head nibble serves CHS head or LOGICAL_BLOCK_MODE bits 27..24 downstream
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         LOGICAL_BLOCK_MODE_O <= 1'b0;
         ADDR_TOP_NIBBLE_O <= '0;
         UNIT_MATCH_O <= 1'b0;
      end
      else
      begin
         LOGICAL_BLOCK_MODE_O <= unit_and_head_select[UH_LBA_BIT];
         ADDR_TOP_NIBBLE_O <= unit_and_head_select[3:0];
         UNIT_MATCH_O <= unit_match;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // device control register, accepted regardless of busy

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         soft_reset_bit <= 1'b0;
         irq_off <= 1'b0;
      end
      else if (WR_I && hit(ADDR_I, OFS_CONTROL))
      begin
         // bits 7..3 and 0 are ignored
         soft_reset_bit <= WDATA_I[CT_SRST];
         irq_off <= WDATA_I[CT_IRQ_OFF];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky status flags; a set beats a same-cycle command or done clear, but reset beats a set

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I || soft_reset_bit)
      begin
         write_fault_flag <= 1'b0;
         transfer_request_flag <= 1'b0;
         fixed_data_flag <= 1'b0;
         error_flag <= 1'b0;
      end
      else
      begin
         if (WRITE_FAULT_I)
            write_fault_flag <= 1'b1;
         else if (NEW_CMD_I)
            write_fault_flag <= 1'b0;
         if (XFER_SET_I)
            transfer_request_flag <= 1'b1;
         else if (NEW_CMD_I || XFER_DONE_I)
            transfer_request_flag <= 1'b0;
         // core keeps running a multi-sector read after a correction
         if (FIXED_DATA_I)
            fixed_data_flag <= 1'b1;
         else if (NEW_CMD_I)
            fixed_data_flag <= 1'b0;
         // failing sector address stays in the address block, not here
         if (CMD_FAIL_I)
            error_flag <= 1'b1;
         else if (NEW_CMD_I)
            error_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pending interrupt: primary status read clears, mirror read does not

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I || soft_reset_bit)
         irq_pending <= 1'b0;
      else if (IRQ_EVENT_I)
         irq_pending <= 1'b1;
      else if (rd_status)
         irq_pending <= 1'b0;
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         CARD_IRQ_N_O <= 1'b1;
         IRQ_CFG_BIT_O <= 1'b0;
      end
      else
      begin
         CARD_IRQ_N_O <= ~(irq_pending && !irq_off && unit_match);
         IRQ_CFG_BIT_O <= irq_pending && !irq_off;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // soft reset outputs and diagnostic code load on reset entry

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         soft_reset_q <= 1'b0;
         SOFT_RESET_O <= 1'b0;
         DIAG_LOAD_O <= 1'b0;
         DIAG_CODE_O <= '0;
      end
      else
      begin
         soft_reset_q <= soft_reset_bit;
         SOFT_RESET_O <= soft_reset_bit;
         DIAG_LOAD_O <= soft_reset_bit && !soft_reset_q;
         DIAG_CODE_O <= DIAG_CODE_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data, registered; one cycle after RD_I

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
         RDATA_O <= '0;
      else if (RD_I)
      begin
         if (hit(ADDR_I, OFS_CONDITION) || hit(ADDR_I, OFS_MIRROR))
            RDATA_O <= card_condition;
         else if (hit(ADDR_I, OFS_READBACK))
            RDATA_O <= unit_selection_readback;
         else if (hit(ADDR_I, OFS_UNIT_HEAD))
            RDATA_O <= unit_and_head_select;
         else
            RDATA_O <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   status_clear_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      rd_status && !IRQ_EVENT_I && !soft_reset_bit |=> !irq_pending)
      else $error("status read did not clear interrupt");
   mirror_keep_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      irq_pending && RD_I && hit(ADDR_I, OFS_MIRROR) && !soft_reset_bit
      |=> irq_pending)
      else $error("mirror read lost interrupt");
   index_zero_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      RD_I && (hit(ADDR_I, OFS_CONDITION) || hit(ADDR_I, OFS_MIRROR))
      |=> !RDATA_O[ST_INDEX])
      else $error("index bit not zero");
   busy_in_reset_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      soft_reset_bit && RD_I && hit(ADDR_I, OFS_MIRROR)
      |=> RDATA_O[ST_BUSY] && !RDATA_O[ST_READY])
      else $error("busy not shown in soft reset");
   irq_mask_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      irq_off |=> CARD_IRQ_N_O && !IRQ_CFG_BIT_O)
      else $error("masked interrupt asserted");
   ctrl_any_time_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      WR_I && hit(ADDR_I, OFS_CONTROL) |=>
      soft_reset_bit == $past(WDATA_I[CT_SRST])
      && irq_off == $past(WDATA_I[CT_IRQ_OFF]))
      else $error("control write not taken");
   head_invert_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      RD_I && hit(ADDR_I, OFS_READBACK) |=>
      RDATA_O[5:2] == ~$past(unit_and_head_select[3:0]))
      else $error("readback head bits wrong");
   write_gate_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      RD_I && hit(ADDR_I, OFS_READBACK) |=>
      RDATA_O[6] == !$past(WRITE_ACTIVE_I))
      else $error("write gate bit wrong");
   unit_bits_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      RD_I && hit(ADDR_I, OFS_READBACK) |=>
      RDATA_O[1:0] == ~$past({unit_select && UNIT_NUMBER_I,
                              !unit_select && !UNIT_NUMBER_I}))
      else $error("readback unit bits wrong");
   err_clear_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      NEW_CMD_I && !CMD_FAIL_I |=> !error_flag)
      else $error("error bit not cleared by command");
   xfer_clear_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      NEW_CMD_I && !XFER_SET_I |=> !transfer_request_flag)
      else $error("transfer request not cleared by command");
   fault_set_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      WRITE_FAULT_I && !soft_reset_bit |=> write_fault_flag)
      else $error("write fault not recorded");
   fixed_set_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      FIXED_DATA_I && !soft_reset_bit |=> fixed_data_flag)
      else $error("corrected data not recorded");
   seek_ready_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      CORE_READY_I && !soft_reset_bit |-> card_condition[ST_SEEK])
      else $error("ready card does not show seek bit");
   ready_hold_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      !CORE_READY_I || soft_reset_bit |-> !card_condition[ST_READY])
      else $error("ready shown before card can accept");
   lba_mode_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      1'b1 |=> LOGICAL_BLOCK_MODE_O
      == $past(unit_and_head_select[UH_LBA_BIT]))
      else $error("block mode output wrong");
   head_nibble_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      1'b1 |=> ADDR_TOP_NIBBLE_O == $past(unit_and_head_select[3:0]))
      else $error("head nibble output wrong");
   unit_match_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      1'b1 |=> UNIT_MATCH_O
      == $past(unit_and_head_select[UH_UNIT_BIT] == UNIT_NUMBER_I))
      else $error("unit match output wrong");
   irq_unit_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      !unit_match |=> CARD_IRQ_N_O)
      else $error("interrupt from unselected unit");
   reset_clear_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      soft_reset_bit |=> !error_flag && !transfer_request_flag
      && !write_fault_flag && !irq_pending)
      else $error("soft reset left status set");
   diag_pulse_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      $rose(soft_reset_bit) |=> DIAG_LOAD_O ##1 !DIAG_LOAD_O)
      else $error("diagnostic load not one pulse");
endmodule

// *** test/ata_host_model.sv ***
// host side model driving the task file strobes, offset and write data
`timescale 1ns/10ps
module ata_host_model
(
   input wire logic clk_i,
   output logic rd_o,
   output logic wr_o,
   output logic [3:0] addr_o,
   output logic [7:0] wdata_o,
   input wire logic [7:0] rdata_i
);
   initial
   begin
      rd_o = 1'b0;
      wr_o = 1'b0;
      addr_o = 4'h0;
      wdata_o = 8'h00;
   end
   // one byte write; idle data shows the inverse so stale values never pass
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask
   // byte reads only, word access never issued
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      addr_o = ~a;
      d = rdata_i;
   endtask
endmodule

// *** test/ata_task_file_status_control_tb_top.sv ***
// bench for the task file status and control register bank
`timescale 1ns/10ps
module ata_task_file_status_control_tb_top;
   import taskfile_pkg::*;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
$display("unexpected t=%0t got %h exp %h", $time, g, e); end end
   logic clk, rst, unit_num, busy, ready, wact, rd, wr;
   logic [6:0] ev;
   logic [3:0] addr, nib;
   logic [7:0] wdata, rdata, diag, d;
   logic irq_n, cfg, srst, dload, lbm, umatch;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;
   ata_host_model host_u (.clk_i(clk), .rd_o(rd), .wr_o(wr), .addr_o(addr),
      .wdata_o(wdata), .rdata_i(rdata));
   taskfile_status_ctrl dut_u (.SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
      .RD_I(rd), .WR_I(wr), .WDATA_I(wdata), .UNIT_NUMBER_I(unit_num),
      .CORE_BUSY_I(busy), .CORE_READY_I(ready), .WRITE_FAULT_I(ev[0]),
      .XFER_SET_I(ev[1]), .XFER_DONE_I(ev[2]), .FIXED_DATA_I(ev[3]),
      .CMD_FAIL_I(ev[4]), .NEW_CMD_I(ev[5]), .WRITE_ACTIVE_I(wact),
      .IRQ_EVENT_I(ev[6]), .RDATA_O(rdata), .CARD_IRQ_N_O(irq_n),
      .IRQ_CFG_BIT_O(cfg), .SOFT_RESET_O(srst), .DIAG_CODE_O(diag),
      .DIAG_LOAD_O(dload), .LOGICAL_BLOCK_MODE_O(lbm),
      .ADDR_TOP_NIBBLE_O(nib), .UNIT_MATCH_O(umatch));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic report_and_stop();
      if (n_mismatch == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // hang guard well above the roughly 100 cycles the sequence needs
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic pulse(input logic [6:0] m);
      @(negedge clk);
      ev = m;
      @(negedge clk);
      ev = 7'h00;
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst = 1'b1;
      unit_num = 1'b0;
      busy = 1'b0;
      ready = 1'b0;
      wact = 1'b0;
      ev = 7'h00;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      host_u.rd_reg(OFS_CONDITION, d);
      `CHK(d, 8'h00)
      `CHK(irq_n, 1'b1)
      ready = 1'b1;
      host_u.rd_reg(OFS_CONDITION, d);
      `CHK(d, 8'h50)
      // lba mode, unit 0, head nibble 5
      host_u.wr_reg(OFS_UNIT_HEAD, 8'hE5);
      settle(1);
      `CHK(lbm, 1'b1)
      `CHK(nib, 4'h5)
      `CHK(umatch, 1'b1)
      host_u.rd_reg(OFS_UNIT_HEAD, d);
      `CHK(d, 8'hE5)
      host_u.rd_reg(OFS_READBACK, d);
      `CHK(d[6:0], 7'h6A)
      wact = 1'b1;
      host_u.rd_reg(OFS_READBACK, d);
      `CHK(d[6:0], 7'h2A)
      wact = 1'b0;
      // bits 7 and 5 read back as ones whatever is written
      host_u.wr_reg(OFS_UNIT_HEAD, 8'h10);
      host_u.rd_reg(OFS_UNIT_HEAD, d);
      `CHK(d, 8'hB0)
      host_u.rd_reg(OFS_READBACK, d);
      `CHK(d[6:0], 7'h7F)
      settle(1);
      `CHK({lbm, umatch}, 2'b00)
      unit_num = 1'b1;
      host_u.rd_reg(OFS_READBACK, d);
      `CHK(d[1:0], 2'b01)
      `CHK(umatch, 1'b1)
      unit_num = 1'b0;
      host_u.wr_reg(OFS_UNIT_HEAD, 8'hA0);
      pulse(7'h1B);
      host_u.rd_reg(OFS_MIRROR, d);
      `CHK(d, 8'h7D)
      `CHK(d[5], 1'b1)
      `CHK(d[2], 1'b1)
      `CHK(d[1], 1'b0)
      pulse(7'h20);
      host_u.rd_reg(OFS_CONDITION, d);
      `CHK(d & 8'h09, 8'h00)
      pulse(7'h02);
      pulse(7'h04);
      host_u.rd_reg(OFS_CONDITION, d);
      `CHK(d[3], 1'b0)
      pulse(7'h40);
      settle(2);
      `CHK({irq_n, cfg}, 2'b01)
      host_u.rd_reg(OFS_MIRROR, d);
      settle(2);
      `CHK(irq_n, 1'b0)
      host_u.rd_reg(OFS_CONDITION, d);
      settle(2);
      `CHK({irq_n, cfg}, 2'b10)
      host_u.wr_reg(OFS_CONTROL, 8'h02);
      pulse(7'h40);
      settle(2);
      `CHK({irq_n, cfg}, 2'b10)
      host_u.wr_reg(OFS_CONTROL, 8'h00);
      settle(2);
      `CHK(irq_n, 1'b0)
      host_u.rd_reg(OFS_CONDITION, d);
      busy = 1'b1;
      pulse(7'h01);
      host_u.rd_reg(OFS_CONDITION, d);
      `CHK(d[7], 1'b1)
      host_u.wr_reg(OFS_CONTROL, 8'h04);
      settle(1);
      `CHK({srst, dload, diag}, {2'b11, DIAG_CODE_RESET})
      settle(1);
      `CHK({srst, dload}, 2'b10)
      // core idle, so busy can only come from the soft reset
      busy = 1'b0;
      host_u.rd_reg(OFS_MIRROR, d);
      `CHK(d, 8'h80)
      host_u.wr_reg(OFS_CONTROL, 8'h00);
      settle(2);
      `CHK(srst, 1'b0)
      host_u.rd_reg(OFS_CONDITION, d);
      `CHK(d, 8'h50)
      report_and_stop();
   end
endmodule
